// ---- cpd_fetch_model.sv ----
// Fetch queue model: offers one aligned instruction per valid cycle to the decoder.
// Assumes the bench pushes whole instructions and drives nothing else of the queue side.
`timescale 1ns/1ps
module cpd_fetch_model (
	input  wire logic       clk_sys,
	input  wire logic       nrst,
	input  wire logic       slow,
	output logic            in_valid,
	output logic [7:0]      in_byte0,
	output logic [7:0]      in_byte1
);
	logic [15:0] q [$];
	logic [15:0] head;

	initial begin
		in_valid = 1'b0;
		in_byte0 = 8'h00;
		in_byte1 = 8'hFF;
	end

	task automatic push(input logic [7:0] b0, input logic [7:0] b1);
		q.push_back({b0, b1});
	endtask

	// Slow mode leaves random idle cycles between instructions
	always @(negedge clk_sys) begin
		if (nrst && q.size() != 0 && !(slow && ($urandom % 3) == 0)) begin
			head = q.pop_front();
			in_valid <= 1'b1;
			in_byte0 <= head[15:8];
			in_byte1 <= head[7:0];
		end else begin
			in_valid <= 1'b0;
			// Released bytes toggle so a stale byte never looks like a live one
			in_byte0 <= ~in_byte0;
			in_byte1 <= ~in_byte1;
		end
	end
endmodule // cpd_fetch_model

// ---- cpd_len_calc.sv ----
// Instruction length calculator of the opcode decoder.
// Assumes the opcode logic has already classified the addressing byte and data bytes.
`timescale 1ns/1ps
module cpd_len_calc (
	cpd_len_if.calc lif
);
	import cpd_pkg::*;

	logic [1:0] disp;

	always_comb begin
		disp = lif.has_modrm ? cpd_disp_bytes(lif.modrm) : 2'h0;
		// Displacement precedes the data bytes, so both simply add
		lif.total_len = lif.base_len + LEN_W'(lif.has_modrm) + LEN_W'(disp) + LEN_W'(lif.imm_bytes);
	end
endmodule // cpd_len_calc

// ---- cpd_len_if.sv ----
// Carrier between the decoder and its length calculator.
// Assumes both ends share one clock; the path is purely combinational.
`timescale 1ns/1ps
interface cpd_len_if;
	import cpd_pkg::*;
	logic                 has_modrm;
	logic [7:0]           modrm;
	logic [1:0]           imm_bytes;
	logic [LEN_W-1:0]     base_len;
	logic [LEN_W-1:0]     total_len;
	modport req  (output has_modrm, output modrm, output imm_bytes, output base_len, input total_len);
	modport calc (input has_modrm, input modrm, input imm_bytes, input base_len, output total_len);
endinterface

// ---- cpd_opcode_decoder.sv ----
// Opcode decoder for arithmetic, logic, string and control-transfer instructions.
// Assumes the fetch queue presents an opcode byte and its following byte in one cycle.
`timescale 1ns/1ps
module cpd_opcode_decoder (
	input  wire logic             clk_sys,
	input  wire logic             nrst,
	input  wire logic             in_valid,
	input  wire logic [7:0]       in_byte0,
	input  wire logic [7:0]       in_byte1,
	output logic                  dec_valid,
	output cpd_pkg::cpd_op_t      dec_op,
	output logic                  dec_word,
	output logic                  dec_dir,
	output logic                  dec_count_cl,
	output logic                  dec_flags_only,
	output logic                  dec_has_modrm,
	output logic [2:0]            dec_alu_sel,
	output logic                  dec_pfx_active,
	output logic                  dec_pfx_zf,
	output logic [cpd_pkg::LEN_W-1:0] dec_len,
	output logic                  dec_illegal
);
	import cpd_pkg::*;

	typedef struct packed {
		logic             valid;
		cpd_op_t          op;
		logic             word;
		logic             dir;
		logic             count_cl;
		logic             flags_only;
		logic             has_modrm;
		logic [2:0]       alu_sel;
		logic             pfx_active;
		logic             pfx_zf;
		logic [LEN_W-1:0] len;
		logic             illegal;
		cpd_fsm_t         fsm;
		logic             pend_zf;
	} cpd_state_t;

	localparam cpd_state_t STATE_RST = '{valid: 1'b0, op: OP_UNKNOWN, word: 1'b0, dir: 1'b0,
		count_cl: 1'b0, flags_only: 1'b0, has_modrm: 1'b0, alu_sel: 3'h0, pfx_active: 1'b0,
		pfx_zf: 1'b0, len: 3'h0, illegal: 1'b0, fsm: FSM_PLAIN, pend_zf: 1'b0};

	cpd_state_t       s;
	cpd_state_t       next_s;
	cpd_len_if        lif ();
	logic [2:0]       fld;
	logic [1:0]       imm;
	logic [LEN_W-1:0] base;
	logic             modrm;
	logic             is_str;

	cpd_len_calc u_len (
		.lif (lif.calc)
	);

	assign lif.has_modrm = modrm;
	assign lif.modrm     = in_byte1;
	assign lif.imm_bytes = imm;
	assign lif.base_len  = base;

	always_comb begin
		next_s       = s;
		fld          = in_byte1[POS_REG +: 3];
		imm          = 2'h0;
		base         = LEN_ONE;
		modrm        = 1'b0;
		is_str       = 1'b0;
		next_s.valid = in_valid;
		next_s.op         = OP_UNKNOWN;
		next_s.word       = in_byte0[POS_W];
		next_s.dir        = 1'b0;
		next_s.count_cl   = 1'b0;
		next_s.flags_only = 1'b0;
		next_s.alu_sel    = 3'h0;
		next_s.illegal    = 1'b0;
		next_s.pfx_active = 1'b0;
		next_s.pfx_zf     = 1'b0;
		if (cpd_match(in_byte0, MSK_DW, OPC_BSUB_RM)) begin
			next_s.op  = OP_BORROW_SUB;
			next_s.dir = in_byte0[POS_D];
			modrm      = 1'b1;
		end else if (cpd_match(in_byte0, MSK_W, OPC_BSUB_AC)) begin
			next_s.op = OP_BORROW_SUB;
			imm       = cpd_imm_bytes(in_byte0[POS_W]);
		end else if (in_byte0 == OPC_ASC_ADD) begin
			next_s.op = OP_ASCII_ADD;
		end else if (in_byte0 == OPC_BCD_ADD) begin
			next_s.op = OP_BCD_ADD;
		end else if (in_byte0 == OPC_ASC_SUB) begin
			next_s.op = OP_ASCII_SUB;
		end else if (in_byte0 == OPC_BCD_SUB) begin
			next_s.op = OP_BCD_SUB;
		end else if (cpd_match(in_byte0, MSK_W, OPC_GRP_F6)) begin
			modrm = 1'b1;
			case (fld)
				3'h0: begin
					next_s.op         = OP_TEST;
					next_s.flags_only = 1'b1;
					imm               = cpd_imm_bytes(in_byte0[POS_W]);
				end
				3'h2: next_s.op = OP_INVERT;
				3'h3: next_s.op = OP_SIGN_CHG;
				3'h4: next_s.op = OP_UPRODUCT;
				3'h5: next_s.op = OP_SMULTIPLY;
				3'h6: next_s.op = OP_UQUOTIENT;
				3'h7: next_s.op = OP_SDIVIDE;
				default: next_s.illegal = 1'b1;
			endcase
		end else if (in_byte0 == OPC_PFIX || in_byte0 == OPC_QFIX) begin
			// Both bytes leave the queue together; a wrong second byte is flagged
			next_s.op      = (in_byte0 == OPC_PFIX) ? OP_APROD_FIX : OP_AQUOT_FIX;
			base           = LEN_TWO;
			next_s.illegal = (in_byte1 != FIX_BASE);
		end else if (in_byte0 == OPC_EXT_B) begin
			next_s.op = OP_BYTE_EXT;
		end else if (in_byte0 == OPC_EXT_W) begin
			next_s.op = OP_WORD_EXT;
		end else if (cpd_match(in_byte0, MSK_DW, OPC_SHIFT)) begin
			modrm           = 1'b1;
			next_s.count_cl = in_byte0[POS_V];
			case (fld)
				3'h0: next_s.op = OP_ROT_L;
				3'h1: next_s.op = OP_ROT_R;
				3'h2: next_s.op = OP_CROT_L;
				3'h3: next_s.op = OP_CROT_R;
				3'h4: next_s.op = OP_SHIFT_L;
				3'h5: next_s.op = OP_SHIFT_R;
				3'h7: next_s.op = OP_ASHIFT_R;
				default: next_s.illegal = 1'b1;
			endcase
		end else if (cpd_match(in_byte0, MSK_DW, OPC_AND_RM)) begin
			next_s.op  = OP_AND;
			next_s.dir = in_byte0[POS_D];
			modrm      = 1'b1;
		end else if (cpd_match(in_byte0, MSK_W, OPC_AND_ACC)) begin
			next_s.op = OP_AND;
			imm       = cpd_imm_bytes(in_byte0[POS_W]);
		end else if (cpd_match(in_byte0, MSK_W, OPC_TST_RM)) begin
			next_s.op         = OP_TEST;
			next_s.flags_only = 1'b1;
			modrm             = 1'b1;
		end else if (cpd_match(in_byte0, MSK_W, OPC_TST_ACC)) begin
			next_s.op         = OP_TEST;
			next_s.flags_only = 1'b1;
			imm               = cpd_imm_bytes(in_byte0[POS_W]);
		end else if (cpd_match(in_byte0, MSK_W, OPC_SMOVE)) begin
			next_s.op = OP_STR_MOVE;
			is_str    = 1'b1;
		end else if (cpd_match(in_byte0, MSK_W, OPC_SCMP)) begin
			next_s.op = OP_STR_CMP;
			is_str    = 1'b1;
		end else if (cpd_match(in_byte0, MSK_W, OPC_SSCAN)) begin
			next_s.op = OP_STR_SCAN;
			is_str    = 1'b1;
		end else if (cpd_match(in_byte0, MSK_W, OPC_SLOAD)) begin
			next_s.op = OP_STR_LOAD;
			is_str    = 1'b1;
		end else if (cpd_match(in_byte0, MSK_W, OPC_SSTORE)) begin
			next_s.op = OP_STR_STORE;
			is_str    = 1'b1;
		end else if (cpd_match(in_byte0, MSK_W, OPC_ITER)) begin
			next_s.op = OP_ITER_PFX;
		end else if (in_byte0 == OPC_BR_NEAR) begin
			next_s.op = OP_BR_NEAR;
			base      = LEN_THREE;
		end else if (in_byte0 == OPC_BR_SHRT) begin
			next_s.op = OP_BR_SHORT;
			base      = LEN_TWO;
		end else if (in_byte0 == OPC_BR_FAR) begin
			next_s.op = OP_BR_FAR;
			base      = LEN_FAR;
		end else if (in_byte0 == OPC_EXIT) begin
			next_s.op = OP_CALL_EXIT;
		end else if (in_byte0 == OPC_EXIT_D) begin
			next_s.op = OP_CALL_EXIT;
			base      = LEN_THREE;
		end else if (cpd_match(in_byte0, MSK_DW, OPC_ALU_IMM)) begin
			// Sign-extended form s:w = 11 carries a single data byte
			next_s.op      = OP_ALU_IMM;
			next_s.alu_sel = fld;
			modrm          = 1'b1;
			imm            = (in_byte0[1:0] == 2'h1) ? 2'h2 : 2'h1;
		end else begin
			next_s.illegal = 1'b1;
		end
		next_s.has_modrm = modrm;
		next_s.len       = lif.total_len;
		// A pending prefix is used by the next instruction only; other opcodes drop it
		if (in_valid) begin
			if (next_s.op == OP_ITER_PFX) begin
				next_s.fsm     = FSM_PFX;
				next_s.pend_zf = in_byte0[POS_Z];
			end else begin
				next_s.fsm = FSM_PLAIN;
				if (s.fsm == FSM_PFX && is_str) begin
					next_s.pfx_active = 1'b1;
					next_s.pfx_zf     = (next_s.op == OP_STR_CMP || next_s.op == OP_STR_SCAN) && s.pend_zf;
				end
			end
		end
		case (s.fsm)
			FSM_PLAIN, FSM_PFX: ;
			default: next_s.fsm = FSM_PLAIN;
		endcase
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			s <= STATE_RST;
		end else begin
			s <= next_s;
		end
	end

	assign dec_valid      = s.valid;
	assign dec_op         = s.op;
	assign dec_word       = s.word;
	assign dec_dir        = s.dir;
	assign dec_count_cl   = s.count_cl;
	assign dec_flags_only = s.flags_only;
	assign dec_has_modrm  = s.has_modrm;
	assign dec_alu_sel    = s.alu_sel;
	assign dec_pfx_active = s.pfx_active;
	assign dec_pfx_zf     = s.pfx_zf;
	assign dec_len        = s.len;
	assign dec_illegal    = s.illegal;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	property p_bsub_rm;
		in_valid && cpd_match(in_byte0, MSK_DW, OPC_BSUB_RM)
			|=> dec_op == OP_BORROW_SUB && dec_has_modrm && dec_dir == $past(in_byte0[POS_D]);
	endproperty
	a_bsub_rm: assert property (p_bsub_rm) else $error("borrow subtract register form misdecoded");

	property p_bsub_acc;
		in_valid && cpd_match(in_byte0, MSK_W, OPC_BSUB_AC)
			|=> dec_op == OP_BORROW_SUB && dec_len == LEN_ONE + 3'($past(in_byte0[0])) + 3'h1;
	endproperty
	a_bsub_acc: assert property (p_bsub_acc) else $error("borrow subtract immediate length wrong");

	property p_add_fix;
		in_valid && in_byte0 == OPC_ASC_ADD |=> dec_op == OP_ASCII_ADD && dec_len == LEN_ONE;
	endproperty
	a_add_fix: assert property (p_add_fix) else $error("ascii add fixup misdecoded");

	property p_sub_fix;
		in_valid && in_byte0 == OPC_BCD_SUB |=> dec_op == OP_BCD_SUB && dec_len == LEN_ONE && !dec_has_modrm;
	endproperty
	a_sub_fix: assert property (p_sub_fix) else $error("bcd subtract fixup misdecoded");

	property p_grp_smult;
		in_valid && cpd_match(in_byte0, MSK_W, OPC_GRP_F6) && in_byte1[5:3] == 3'h5 |=> dec_op == OP_SMULTIPLY;
	endproperty
	a_grp_smult: assert property (p_grp_smult) else $error("signed multiply not selected");

	property p_prod_fix;
		in_valid && in_byte0 == OPC_PFIX && in_byte1 == FIX_BASE
			|=> dec_op == OP_APROD_FIX && dec_len == LEN_TWO && !dec_illegal;
	endproperty
	a_prod_fix: assert property (p_prod_fix) else $error("ascii product fixup not two bytes");

	property p_quot_fix;
		in_valid && in_byte0 == OPC_QFIX |=> dec_op == OP_AQUOT_FIX && dec_len == LEN_TWO;
	endproperty
	a_quot_fix: assert property (p_quot_fix) else $error("ascii quotient fixup not two bytes");

	property p_extend;
		in_valid && in_byte0 == OPC_EXT_W |=> dec_op == OP_WORD_EXT && dec_len == LEN_ONE;
	endproperty
	a_extend: assert property (p_extend) else $error("word extend misdecoded");

	property p_shift_sel;
		in_valid && cpd_match(in_byte0, MSK_DW, OPC_SHIFT) && in_byte1[5:3] == 3'h7 |=> dec_op == OP_ASHIFT_R;
	endproperty
	a_shift_sel: assert property (p_shift_sel) else $error("arithmetic right shift not selected");

	property p_and_acc;
		in_valid && cpd_match(in_byte0, MSK_W, OPC_AND_ACC) |=> dec_op == OP_AND && !dec_has_modrm;
	endproperty
	a_and_acc: assert property (p_and_acc) else $error("and immediate form misdecoded");

	property p_test_flags;
		dec_valid && dec_op == OP_TEST |-> dec_flags_only;
	endproperty
	a_test_flags: assert property (p_test_flags) else $error("test writes back a result");

	property p_branch_far;
		in_valid && in_byte0 == OPC_BR_FAR |=> dec_op == OP_BR_FAR && dec_len == LEN_FAR;
	endproperty
	a_branch_far: assert property (p_branch_far) else $error("far branch length wrong");

	property p_exit_imm;
		in_valid && in_byte0 == OPC_EXIT_D |=> dec_op == OP_CALL_EXIT && dec_len == LEN_THREE;
	endproperty
	a_exit_imm: assert property (p_exit_imm) else $error("call exit with data length wrong");

	property p_width;
		in_valid |=> dec_word == $past(in_byte0[POS_W]);
	endproperty
	a_width: assert property (p_width) else $error("width bit not followed");

	property p_count;
		in_valid && cpd_match(in_byte0, MSK_DW, OPC_SHIFT) |=> dec_count_cl == $past(in_byte0[POS_V]);
	endproperty
	a_count: assert property (p_count) else $error("shift count select wrong");

	sequence s_prefix_z;
		in_valid && in_byte0 == (OPC_ITER | 8'h01);
	endsequence
	sequence s_scan_next;
		in_valid && cpd_match(in_byte0, MSK_W, OPC_SSCAN);
	endsequence
	property p_pfx_zf;
		s_prefix_z ##1 s_scan_next |=> dec_pfx_active && dec_pfx_zf && dec_op == OP_STR_SCAN;
	endproperty
	a_pfx_zf: assert property (p_pfx_zf) else $error("repeat zero condition lost");

	property p_len_modrm;
		in_valid && cpd_match(in_byte0, MSK_DW, OPC_AND_RM) && in_byte1[7:6] == 2'h2 |=> dec_len == 3'h4;
	endproperty
	a_len_modrm: assert property (p_len_modrm) else $error("length with word displacement wrong");
endmodule // cpd_opcode_decoder

// ---- cpd_pkg.sv ----
// Constants, opcode patterns and helper functions of the opcode decoder.
// Assumes the fetch queue offers the opcode byte and the byte after it together.
package cpd_pkg;
	localparam int           LEN_W       = 3;
	localparam int           POS_W       = 0;
	localparam int           POS_D       = 1;
	localparam int           POS_V       = 1;
	localparam int           POS_Z       = 0;
	localparam int           POS_MOD     = 6;
	localparam int           POS_REG     = 3;
	localparam logic [7:0]   MSK_FULL    = 8'hFF;
	localparam logic [7:0]   MSK_W       = 8'hFE;
	localparam logic [7:0]   MSK_DW      = 8'hFC;
	localparam logic [7:0]   OPC_BSUB_RM = 8'h18;
	localparam logic [7:0]   OPC_BSUB_AC = 8'h1C;
	localparam logic [7:0]   OPC_ASC_ADD = 8'h37;
	localparam logic [7:0]   OPC_BCD_ADD = 8'h27;
	localparam logic [7:0]   OPC_ASC_SUB = 8'h3F;
	localparam logic [7:0]   OPC_BCD_SUB = 8'h2F;
	localparam logic [7:0]   OPC_GRP_F6  = 8'hF6;
	localparam logic [7:0]   OPC_PFIX    = 8'hD4;
	localparam logic [7:0]   OPC_QFIX    = 8'hD5;
	localparam logic [7:0]   FIX_BASE    = 8'h0A;
	localparam logic [7:0]   OPC_EXT_B   = 8'h98;
	localparam logic [7:0]   OPC_EXT_W   = 8'h99;
	localparam logic [7:0]   OPC_SHIFT   = 8'hD0;
	localparam logic [7:0]   OPC_AND_RM  = 8'h20;
	localparam logic [7:0]   OPC_AND_ACC = 8'h24;
	localparam logic [7:0]   OPC_TST_RM  = 8'h84;
	localparam logic [7:0]   OPC_TST_ACC = 8'hA8;
	localparam logic [7:0]   OPC_SMOVE   = 8'hA4;
	localparam logic [7:0]   OPC_SCMP    = 8'hA6;
	localparam logic [7:0]   OPC_SSCAN   = 8'hAE;
	localparam logic [7:0]   OPC_SLOAD   = 8'hAC;
	localparam logic [7:0]   OPC_SSTORE  = 8'hAA;
	localparam logic [7:0]   OPC_ITER    = 8'hF2;
	localparam logic [7:0]   OPC_BR_NEAR = 8'hE9;
	localparam logic [7:0]   OPC_BR_SHRT = 8'hEB;
	localparam logic [7:0]   OPC_BR_FAR  = 8'hEA;
	localparam logic [7:0]   OPC_EXIT    = 8'hC3;
	localparam logic [7:0]   OPC_EXIT_D  = 8'hC2;
	localparam logic [7:0]   OPC_ALU_IMM = 8'h80;
	localparam logic [LEN_W-1:0] LEN_ONE   = 3'h1;
	localparam logic [LEN_W-1:0] LEN_TWO   = 3'h2;
	localparam logic [LEN_W-1:0] LEN_THREE = 3'h3;
	localparam logic [LEN_W-1:0] LEN_FAR   = 3'h5;

	typedef enum logic [5:0] {
		OP_UNKNOWN   = 6'h00, OP_BORROW_SUB = 6'h01, OP_ASCII_ADD = 6'h02, OP_BCD_ADD  = 6'h03,
		OP_ASCII_SUB = 6'h04, OP_BCD_SUB    = 6'h05, OP_TEST      = 6'h06, OP_INVERT   = 6'h07,
		OP_SIGN_CHG  = 6'h08, OP_UPRODUCT   = 6'h09, OP_SMULTIPLY = 6'h0A, OP_UQUOTIENT = 6'h0B,
		OP_SDIVIDE   = 6'h0C, OP_APROD_FIX  = 6'h0D, OP_AQUOT_FIX = 6'h0E, OP_BYTE_EXT = 6'h0F,
		OP_WORD_EXT  = 6'h10, OP_ROT_L      = 6'h11, OP_ROT_R     = 6'h12, OP_CROT_L   = 6'h13,
		OP_CROT_R    = 6'h14, OP_SHIFT_L    = 6'h15, OP_SHIFT_R   = 6'h16, OP_ASHIFT_R = 6'h17,
		OP_AND       = 6'h18, OP_STR_MOVE   = 6'h19, OP_STR_CMP   = 6'h1A, OP_STR_SCAN = 6'h1B,
		OP_STR_LOAD  = 6'h1C, OP_STR_STORE  = 6'h1D, OP_ITER_PFX  = 6'h1E, OP_BR_NEAR  = 6'h1F,
		OP_BR_SHORT  = 6'h20, OP_BR_FAR     = 6'h21, OP_CALL_EXIT = 6'h22, OP_ALU_IMM  = 6'h23
	} cpd_op_t;

	typedef enum logic [1:0] {
		FSM_PLAIN = 2'b01,
		FSM_PFX   = 2'b10
	} cpd_fsm_t;

	function automatic logic cpd_match(input logic [7:0] b, input logic [7:0] m, input logic [7:0] v);
		return (b & m) == v;
	endfunction

	function automatic logic [1:0] cpd_imm_bytes(input logic w);
		return w ? 2'h2 : 2'h1;
	endfunction

	// Direct address form (mod 00, r/m 110) carries a full displacement
	function automatic logic [1:0] cpd_disp_bytes(input logic [7:0] modrm);
		case (modrm[7:6])
			2'h1: return 2'h1;
			2'h2: return 2'h2;
			2'h0: return (modrm[2:0] == 3'h6) ? 2'h2 : 2'h0;
			default: return 2'h0;
		endcase
	endfunction
endpackage

// ---- tb_cpu16_opcode_decoder.sv ----
// Testbench of the opcode decoder: reference model compared at every decoded instruction.
// Assumes the fetch model presents aligned instructions; outputs follow one cycle later.
`timescale 1ns/1ps
module tb_cpu16_opcode_decoder;
	import cpd_pkg::*;
	localparam cpd_op_t GRP_F6 [8] = '{OP_TEST, OP_UNKNOWN, OP_INVERT, OP_SIGN_CHG,
		OP_UPRODUCT, OP_SMULTIPLY, OP_UQUOTIENT, OP_SDIVIDE};
	localparam cpd_op_t GRP_SH [8] = '{OP_ROT_L, OP_ROT_R, OP_CROT_L, OP_CROT_R,
		OP_SHIFT_L, OP_SHIFT_R, OP_UNKNOWN, OP_ASHIFT_R};
	localparam logic [7:0] OPC_LIST [51] = '{8'h18, 8'h19, 8'h1A, 8'h1B, 8'h1C, 8'h1D, 8'h37, 8'h27, 8'h3F,
		8'h2F, 8'hF6, 8'hF7, 8'hD4, 8'hD5, 8'h98, 8'h99, 8'hD0, 8'hD1, 8'hD2, 8'hD3, 8'h20, 8'h21, 8'h22,
		8'h23, 8'h24, 8'h25, 8'h84, 8'h85, 8'hA8, 8'hA9, 8'hA4, 8'hA5, 8'hA6, 8'hA7, 8'hAE, 8'hAF, 8'hAC,
		8'hAD, 8'hAA, 8'hAB, 8'hF2, 8'hF3, 8'hE9, 8'hEB, 8'hEA, 8'hC3, 8'hC2, 8'h80, 8'h81, 8'h82, 8'h83};
	localparam logic [7:0] PFX_SEQ [11] = '{8'hF3, 8'hAE, 8'hF2, 8'hA6, 8'hF3, 8'hA4, 8'hF2, 8'h98, 8'hAE,
		8'hF3, 8'hA7};

	logic             clk_sys = 1'b0;
	logic             nrst;
	logic             slow;
	logic             in_valid;
	logic [7:0]       in_byte0;
	logic [7:0]       in_byte1;
	logic             dec_valid;
	cpd_op_t          dec_op;
	logic             dec_word;
	logic             dec_dir;
	logic             dec_count_cl;
	logic             dec_flags_only;
	logic             dec_has_modrm;
	logic [2:0]       dec_alu_sel;
	logic             dec_pfx_active;
	logic             dec_pfx_zf;
	logic [LEN_W-1:0] dec_len;
	logic             dec_illegal;
	int               err_count = 0;
	int               n_compared = 0;
	logic             e_v;
	cpd_op_t          e_op;
	logic             e_word;
	logic             e_dir;
	logic             e_cl;
	logic             e_fo;
	logic             e_hm;
	logic [2:0]       e_alu;
	logic             e_ra;
	logic             e_rz;
	logic             e_il;
	logic [LEN_W-1:0] e_len;
	logic             pend;
	logic             pz;

	always #2.5 clk_sys = ~clk_sys;

	cpd_fetch_model fq (.clk_sys(clk_sys), .nrst(nrst), .slow(slow), .in_valid(in_valid),
		.in_byte0(in_byte0), .in_byte1(in_byte1));

	cpd_opcode_decoder dut (.clk_sys(clk_sys), .nrst(nrst), .in_valid(in_valid), .in_byte0(in_byte0),
		.in_byte1(in_byte1), .dec_valid(dec_valid), .dec_op(dec_op), .dec_word(dec_word), .dec_dir(dec_dir),
		.dec_count_cl(dec_count_cl), .dec_flags_only(dec_flags_only), .dec_has_modrm(dec_has_modrm),
		.dec_alu_sel(dec_alu_sel), .dec_pfx_active(dec_pfx_active), .dec_pfx_zf(dec_pfx_zf),
		.dec_len(dec_len), .dec_illegal(dec_illegal));

	task automatic predict(input logic [7:0] b0, input logic [7:0] b1);
		logic [2:0] r;
		int         disp;
		int         data;
		int         len;
		logic       rm_form;
		r = b1[5:3];
		disp = (b1[7:6] == 2'h1) ? 1 : ((b1[7:6] == 2'h2) || (b1[7:6] == 2'h0 && b1[2:0] == 3'h6)) ? 2 : 0;
		rm_form = b0 inside {[8'h18:8'h1B], [8'h20:8'h23], 8'h84, 8'h85, [8'hD0:8'hD3], 8'hF6, 8'hF7, [8'h80:8'h83]};
		case (b0) inside
			[8'h18:8'h1D]: e_op = OP_BORROW_SUB;
			8'h37: e_op = OP_ASCII_ADD;
			8'h27: e_op = OP_BCD_ADD;
			8'h3F: e_op = OP_ASCII_SUB;
			8'h2F: e_op = OP_BCD_SUB;
			8'hF6, 8'hF7: e_op = GRP_F6[r];
			8'hD4: e_op = OP_APROD_FIX;
			8'hD5: e_op = OP_AQUOT_FIX;
			8'h98: e_op = OP_BYTE_EXT;
			8'h99: e_op = OP_WORD_EXT;
			[8'hD0:8'hD3]: e_op = GRP_SH[r];
			[8'h20:8'h25]: e_op = OP_AND;
			8'h84, 8'h85, 8'hA8, 8'hA9: e_op = OP_TEST;
			8'hA4, 8'hA5: e_op = OP_STR_MOVE;
			8'hA6, 8'hA7: e_op = OP_STR_CMP;
			8'hAE, 8'hAF: e_op = OP_STR_SCAN;
			8'hAC, 8'hAD: e_op = OP_STR_LOAD;
			8'hAA, 8'hAB: e_op = OP_STR_STORE;
			8'hF2, 8'hF3: e_op = OP_ITER_PFX;
			8'hE9: e_op = OP_BR_NEAR;
			8'hEB: e_op = OP_BR_SHORT;
			8'hEA: e_op = OP_BR_FAR;
			8'hC2, 8'hC3: e_op = OP_CALL_EXIT;
			[8'h80:8'h83]: e_op = OP_ALU_IMM;
			default: e_op = OP_UNKNOWN;
		endcase
		e_il = (e_op == OP_UNKNOWN) || (b0 inside {8'hD4, 8'hD5} && b1 != 8'h0A);
		e_word = b0[0];
		e_dir = (b0 inside {[8'h18:8'h1B], [8'h20:8'h23]}) ? b0[1] : 1'b0;
		e_cl = (b0 inside {[8'hD0:8'hD3]}) ? b0[1] : 1'b0;
		e_fo = (e_op == OP_TEST);
		e_hm = rm_form;
		e_alu = (b0 inside {[8'h80:8'h83]}) ? r : 3'h0;
		data = (b0 inside {8'h1C, 8'h1D, 8'h24, 8'h25, 8'hA8, 8'hA9} || (b0 inside {8'hF6, 8'hF7} && r == 3'h0))
			? 1 + b0[0] : 0;
		if (b0 inside {[8'h80:8'h83]})
			data = (b0[1:0] == 2'b01) ? 2 : 1;
		len = 1 + (rm_form ? 1 + disp : 0) + data;
		if (b0 inside {8'hD4, 8'hD5, 8'hEB})
			len = 2;
		if (b0 inside {8'hE9, 8'hC2})
			len = 3;
		if (b0 == 8'hEA)
			len = 5;
		e_len = 3'(len);
		e_ra = pend && (b0 inside {[8'hA4:8'hA7], [8'hAA:8'hAF]});
		e_rz = e_ra && (b0 inside {8'hA6, 8'hA7, 8'hAE, 8'hAF}) && pz;
		pend = b0 inside {8'hF2, 8'hF3};
		pz = b0[0];
	endtask

	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			e_v = 1'b0;
			pend = 1'b0;
		end else begin
			e_v = in_valid;
			if (in_valid)
				predict(in_byte0, in_byte1);
		end
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	// Sampled after the falling edge so reset and register updates have landed
	always @(negedge clk_sys) begin
		#1;
		if (!nrst) begin
			check(8'({dec_valid, dec_illegal, dec_len}), 8'h00, "reset outputs");
			check(8'(dec_op), 8'(OP_UNKNOWN), "reset op");
		end else begin
			check(8'(dec_valid), 8'(e_v), "valid");
			if (e_v) begin
				check(8'(dec_illegal), 8'(e_il), "illegal");
				check(8'(dec_op), 8'(e_op), "operation");
				check(8'(dec_len), 8'(e_len), "length");
				if (!e_il) begin
					check({dec_word, dec_dir, dec_count_cl, dec_has_modrm, dec_alu_sel, 1'b0},
						{e_word, e_dir, e_cl, e_hm, e_alu, 1'b0}, "form");
					check(8'(dec_flags_only), 8'(e_fo), "flags only");
					check(8'({dec_pfx_active, dec_pfx_zf}), 8'({e_ra, e_rz}), "repeat");
				end
			end
		end
	end

	task automatic drain(input string name);
		int n;
		n = 0;
		while (fq.q.size() != 0 && n < 20000) begin
			@(negedge clk_sys);
			n++;
		end
		// A queue that never empties is a hang, counted like any mismatch
		if (fq.q.size() != 0) begin
			err_count++;
			$display("unexpected at %0t: queue did not drain in %s", $time, name);
		end
		repeat (3) @(negedge clk_sys);
		$display("test %s done, mismatches so far %0d", name, err_count);
	endtask

	task automatic test_done();
		$display("compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	initial begin
		nrst = 1'b0;
		slow = 1'b0;
		void'($urandom(72));
		repeat (20) @(negedge clk_sys);
		nrst = 1'b1;
		// Every opcode with each middle field and every mod value (r/m fixed at 110; fixups take 0A for r below 6), back to back
		foreach (OPC_LIST[i])
			for (int r = 0; r < 8; r++)
				fq.push(OPC_LIST[i], (OPC_LIST[i] inside {8'hD4, 8'hD5} && r < 6) ? 8'h0A
					: {2'(r), 3'(r), 3'h6});
		drain("opcode table");
		// Prefix pairing, then again with idle gaps that must keep the prefix pending
		for (int k = 0; k < 2; k++) begin
			slow = k[0];
			foreach (PFX_SEQ[i])
				fq.push(PFX_SEQ[i], 8'($urandom));
			drain("prefix pairing");
		end
		for (int i = 0; i < 1500; i++) begin
			logic [7:0] b0;
			b0 = (($urandom % 8) == 0) ? 8'($urandom) : OPC_LIST[$urandom_range(50)];
			fq.push(b0, (b0 inside {8'hD4, 8'hD5} && ($urandom % 4) != 0) ? 8'h0A : 8'($urandom));
		end
		drain("random stream");
		// A reset between prefix and string op must drop the pending prefix
		fq.push(8'hF3, 8'h00);
		drain("prefix before reset");
		nrst = 1'b0;
		repeat (3) @(negedge clk_sys);
		nrst = 1'b1;
		fq.push(8'hAE, 8'h00);
		drain("reset mid-run");
		test_done();
	end

	initial begin
		#(5ns * 40000);
		err_count++;
		$display("unexpected at %0t: watchdog expired", $time);
		test_done();
	end
endmodule // tb_cpu16_opcode_decoder
